// ---- design/ssp_pkg.sv ----
// Shared constants and types of the synchronous slave serial port.
// Assumes a 32-bit APB slave with byte addresses on an 8-bit paddr.
`default_nettype none
package ssp_pkg;
  // Register byte offsets
  localparam logic [7:0] RX_STATUS_CTRL_OFS = 8'h00;
  localparam logic [7:0] TX_STATUS_CTRL_OFS = 8'h04;
  localparam logic [7:0] TX_HOLDING_OFS = 8'h08;
  localparam logic [7:0] RX_DATA_OFS = 8'h0C;
  localparam logic [7:0] BAUD_POL_CTRL_OFS = 8'h10;
  localparam logic [7:0] BAUD_DIV_LOW_OFS = 8'h14;
  localparam logic [7:0] BAUD_DIV_HIGH_OFS = 8'h18;
  localparam logic [7:0] INT_CTRL_OFS = 8'h1C;
  // receive_status_control fields
  localparam int PORT_ENABLE_BIT = 7;
  localparam int RX_NINE_SEL_BIT = 6;
  localparam int SINGLE_RX_EN_BIT = 5;
  localparam int CONT_RX_EN_BIT = 4;
  localparam int ADDR_DETECT_EN_BIT = 3;
  localparam int FRAMING_ERR_BIT = 2;
  localparam int OVERRUN_BIT = 1;
  localparam int RX_NINTH_BIT = 0;
  // transmit_status_control fields
  localparam int CLOCK_SRC_SEL_BIT = 7;
  localparam int TX_NINE_SEL_BIT = 6;
  localparam int TX_ENABLE_BIT = 5;
  localparam int SYNC_MODE_BIT = 4;
  localparam int BREAK_SEND_BIT = 3;
  localparam int HIGH_BAUD_BIT = 2;
  localparam int SHIFTER_EMPTY_BIT = 1;
  localparam int TX_NINTH_BIT = 0;
  // baud_and_polarity_control fields
  localparam int RECEIVER_IDLE_BIT = 6;
  localparam int DATA_POL_BIT = 5;
  localparam int CLOCK_POL_BIT = 4;
  localparam int WIDE_DIV_BIT = 3;
  localparam int WAKE_EDGE_BIT = 1;
  localparam int AUTO_RATE_BIT = 0;
  // Interrupt control fields
  localparam int RX_INT_EN_BIT = 0;
  localparam int TX_INT_EN_BIT = 1;
  localparam int RX_FLAG_BIT = 4;
  localparam int TX_FLAG_BIT = 5;
  // Writable masks and reset values
  localparam logic [7:0] RX_CTRL_WMASK = 8'hF8;
  localparam logic [7:0] TX_CTRL_WMASK = 8'hFD;
  localparam logic [7:0] BAUD_CTRL_WMASK = 8'h3B;
  localparam logic [7:0] INT_CTRL_WMASK = 8'h03;
  localparam logic [7:0] RX_CTRL_RST = 8'h00;
  localparam logic [7:0] TX_CTRL_RST = 8'h00;
  localparam logic [7:0] BAUD_CTRL_RST = 8'h00;
  localparam logic [7:0] BAUD_DIV_RST = 8'h00;
  localparam logic [7:0] INT_CTRL_RST = 8'h00;
  // Character lengths and receive queue depth
  localparam logic [3:0] CHAR_BITS_EIGHT = 4'h8;
  localparam logic [3:0] CHAR_BITS_NINE = 4'h9;
  localparam int RX_QUEUE_DEPTH = 2;

  typedef struct packed {
    logic ninth;
    logic [7:0] low;
  } ssp_char_t;

  typedef enum {TX_IDLE, TX_SHIFT} ssp_tx_state_t;
endpackage
`default_nettype wire

// ---- design/ssp_pin_sync.sv ----
// Two-stage synchroniser for pin levels entering the mclk domain.
// Assumes each bit is an independent level; no bus coherency.
`default_nettype none
module ssp_pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinSync
);
  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;

  // First stage is read only by the second
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge mclk) begin
      if (rst) begin
        stage1_r[i] <= 1'b0;
        stage2_r[i] <= 1'b0;
      end else begin
        stage1_r[i] <= pinIn[i];
        stage2_r[i] <= stage1_r[i];
      end
    end
  end

  assign pinSync = stage2_r;
endmodule
`default_nettype wire

// ---- design/ssp_rx_queue.sv ----
// Small receive queue with a registered head word.
// Assumes push and pop come from mclk-domain logic.
`default_nettype none
module ssp_rx_queue #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic flush,
  input wire logic push,
  input wire logic [WIDTH-1:0] pushData,
  input wire logic pop,
  output logic [WIDTH-1:0] headData,
  output logic empty,
  output logic full
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  // Sized to the count so that the full compare sees the real depth
  localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
  logic [AW:0] count_r, count_nxt, countAfterPop;
  logic [WIDTH-1:0] head_r, head_nxt;
  logic empty_r, empty_nxt, full_r, full_nxt, doPush, doPop;

  function automatic logic [AW-1:0] wrapInc(input logic [AW-1:0] p);
    return (int'(p) == DEPTH - 1) ? '0 : p + 1'b1;
  endfunction

  always_comb begin
    doPush = push & ~full_r & ~flush;
    doPop = pop & ~empty_r & ~flush;
    wrPtr_nxt = doPush ? wrapInc(wrPtr_r) : wrPtr_r;
    rdPtr_nxt = doPop ? wrapInc(rdPtr_r) : rdPtr_r;
    countAfterPop = count_r - {{AW{1'b0}}, doPop};
    count_nxt = countAfterPop + {{AW{1'b0}}, doPush};
    // A push into an empty slot becomes the head at once
    if (countAfterPop == '0) begin
      head_nxt = doPush ? pushData : '0;
    end else begin
      head_nxt = mem[rdPtr_nxt];
    end
    if (flush) begin
      wrPtr_nxt = '0;
      rdPtr_nxt = '0;
      count_nxt = '0;
      head_nxt = '0;
    end
    empty_nxt = (count_nxt == '0);
    full_nxt = (count_nxt == DEPTH_CNT);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
      head_r <= '0;
      empty_r <= 1'b1;
      full_r <= 1'b0;
    end else begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
      head_r <= head_nxt;
      empty_r <= empty_nxt;
      full_r <= full_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (doPush) begin
      mem[wrPtr_r] <= pushData;
    end
  end

  assign headData = head_r;
  assign empty = empty_r;
  assign full = full_r;
endmodule
`default_nettype wire

// ---- design/ssp_slave_port.sv ----
// Synchronous slave serial port: APB registers, shifters, receive queue.
// Assumes the external master drives clock and data pins; both are async.
//
// Function
// - Transmit direction only when both receive enables clear
// - Nine-bit select shifts nine transmit bits
// - No transmission before transmit enable set
// - Ninth transmit bit from field, loaded first
// - Holding register write starts a transmission
// - Continuous receive keeps receiver running between characters
// - Single-receive enable starts no reception in slave mode
// - Reception continues while core sleeps
// - Completed character moves into receive queue
// - Received character during sleep raises wake when receive interrupt enabled
// - Completion sets receive flag and interrupt
// - Nine-bit select captures nine receive bits
// - Ninth received bit shown in status field
// - Data read returns oldest unread low byte
// - Overrun cleared by receive or port disable
// - Data change leading edge, valid trailing
// - Two-deep queue; third character sets overrun
// - Overrun blocks new characters, queue stays readable
`default_nettype none
module ssp_slave_port (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serialClockPinIn,
  output logic serialClockPinOut,
  output logic serialClockPinOeN,
  input wire logic serialDataPinIn,
  output logic serialDataPinOut,
  output logic serialDataPinOeN,
  input wire logic coreSleep,
  output logic receiveIrq,
  output logic transmitIrq,
  output logic wakeReq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and clock edge detection

  logic clkSync, dataSync, clkLevelPrev_r, clkLevelPrev_nxt, clkLevel;
  logic leadingEdge, trailingEdge;

  ssp_pin_sync #(.WIDTH(2)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .pinIn({serialClockPinIn, serialDataPinIn}),
    .pinSync({clkSync, dataSync})
  );

  logic [7:0] rxCtrl_r, rxCtrl_nxt, txCtrl_r, txCtrl_nxt, baudCtrl_r, baudCtrl_nxt;
  logic [7:0] divLow_r, divLow_nxt, divHigh_r, divHigh_nxt, intCtrl_r, intCtrl_nxt;

  always_comb begin
    // Polarity bit selects which pin level is idle
    clkLevel = clkSync ^ baudCtrl_r[ssp_pkg::CLOCK_POL_BIT];
    clkLevelPrev_nxt = clkLevel;
    leadingEdge = clkLevel & ~clkLevelPrev_r;
    trailingEdge = ~clkLevel & clkLevelPrev_r;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      clkLevelPrev_r <= 1'b0;
    end else begin
      clkLevelPrev_r <= clkLevelPrev_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode

  logic portEnable, slaveMode, contRx, singleRx, txDir, rxNine, txNine, transmit_enable;
  logic portOn, rxOn, overrun_r, overrun_nxt;

  always_comb begin
    portEnable = rxCtrl_r[ssp_pkg::PORT_ENABLE_BIT];
    slaveMode = txCtrl_r[ssp_pkg::SYNC_MODE_BIT] & ~txCtrl_r[ssp_pkg::CLOCK_SRC_SEL_BIT];
    portOn = portEnable & slaveMode;
    contRx = rxCtrl_r[ssp_pkg::CONT_RX_EN_BIT];
    singleRx = rxCtrl_r[ssp_pkg::SINGLE_RX_EN_BIT];
    txDir = ~contRx & ~singleRx;
    rxNine = rxCtrl_r[ssp_pkg::RX_NINE_SEL_BIT];
    txNine = txCtrl_r[ssp_pkg::TX_NINE_SEL_BIT];
    transmit_enable = txCtrl_r[ssp_pkg::TX_ENABLE_BIT];
    // Only the continuous enable starts reception here
    rxOn = portOn & contRx & ~overrun_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave

  logic accessPh, wrDone, rdDone, mapped;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic [7:0] readByte;
  logic qEmpty, qFull, qPush, qPop, txHoldFull_r, txBusy_r, rxActive;
  ssp_pkg::ssp_char_t qHead, rxChar;

  function automatic logic isReg(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  always_comb begin
    accessPh = psel & penable;
    wrDone = accessPh & pready_r & pwrite;
    rdDone = accessPh & pready_r & ~pwrite;
    mapped = 1'b1;
    readByte = 8'h00;
    case (paddr)
      ssp_pkg::RX_STATUS_CTRL_OFS: begin
        readByte = rxCtrl_r;
        readByte[ssp_pkg::OVERRUN_BIT] = overrun_r;
        readByte[ssp_pkg::RX_NINTH_BIT] = qHead.ninth;
      end
      ssp_pkg::TX_STATUS_CTRL_OFS: begin
        readByte = txCtrl_r;
        readByte[ssp_pkg::SHIFTER_EMPTY_BIT] = ~txBusy_r;
      end
      ssp_pkg::TX_HOLDING_OFS: readByte = 8'h00;
      ssp_pkg::RX_DATA_OFS: readByte = qHead.low;
      ssp_pkg::BAUD_POL_CTRL_OFS: begin
        readByte = baudCtrl_r;
        readByte[ssp_pkg::RECEIVER_IDLE_BIT] = ~rxActive;
      end
      ssp_pkg::BAUD_DIV_LOW_OFS: readByte = divLow_r;
      ssp_pkg::BAUD_DIV_HIGH_OFS: readByte = divHigh_r;
      ssp_pkg::INT_CTRL_OFS: begin
        readByte = intCtrl_r;
        readByte[ssp_pkg::RX_FLAG_BIT] = ~qEmpty;
        readByte[ssp_pkg::TX_FLAG_BIT] = ~txHoldFull_r;
      end
      default: mapped = 1'b0;
    endcase
    pready_nxt = accessPh & ~pready_r;
    pslverr_nxt = accessPh & ~pready_r & ~mapped;
    prdata_nxt = (accessPh & ~pready_r & ~pwrite) ? {24'h000000, readByte} : prdata_r;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers and transmit holding

  logic wrTxHold, txLoad, txHoldFull_nxt;
  logic [7:0] txHold_r, txHold_nxt;

  always_comb begin
    rxCtrl_nxt = rxCtrl_r;
    txCtrl_nxt = txCtrl_r;
    baudCtrl_nxt = baudCtrl_r;
    divLow_nxt = divLow_r;
    divHigh_nxt = divHigh_r;
    intCtrl_nxt = intCtrl_r;
    txHold_nxt = txHold_r;
    wrTxHold = wrDone & isReg(paddr, ssp_pkg::TX_HOLDING_OFS);
    if (wrDone & isReg(paddr, ssp_pkg::RX_STATUS_CTRL_OFS)) begin
      rxCtrl_nxt = pwdata[7:0] & ssp_pkg::RX_CTRL_WMASK;
    end
    if (wrDone & isReg(paddr, ssp_pkg::TX_STATUS_CTRL_OFS)) begin
      txCtrl_nxt = pwdata[7:0] & ssp_pkg::TX_CTRL_WMASK;
    end
    if (wrDone & isReg(paddr, ssp_pkg::BAUD_POL_CTRL_OFS)) begin
      baudCtrl_nxt = pwdata[7:0] & ssp_pkg::BAUD_CTRL_WMASK;
    end
    if (wrDone & isReg(paddr, ssp_pkg::BAUD_DIV_LOW_OFS)) begin
      divLow_nxt = pwdata[7:0];
    end
    if (wrDone & isReg(paddr, ssp_pkg::BAUD_DIV_HIGH_OFS)) begin
      divHigh_nxt = pwdata[7:0];
    end
    if (wrDone & isReg(paddr, ssp_pkg::INT_CTRL_OFS)) begin
      intCtrl_nxt = pwdata[7:0] & ssp_pkg::INT_CTRL_WMASK;
    end
    // A write while full replaces the waiting byte
    if (wrTxHold) begin
      txHold_nxt = pwdata[7:0];
    end
    txHoldFull_nxt = (txHoldFull_r & ~txLoad) | wrTxHold;
    if (~portEnable) begin
      txHoldFull_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rxCtrl_r <= ssp_pkg::RX_CTRL_RST;
      txCtrl_r <= ssp_pkg::TX_CTRL_RST;
      baudCtrl_r <= ssp_pkg::BAUD_CTRL_RST;
      divLow_r <= ssp_pkg::BAUD_DIV_RST;
      divHigh_r <= ssp_pkg::BAUD_DIV_RST;
      intCtrl_r <= ssp_pkg::INT_CTRL_RST;
      txHold_r <= 8'h00;
      txHoldFull_r <= 1'b0;
    end else begin
      rxCtrl_r <= rxCtrl_nxt;
      txCtrl_r <= txCtrl_nxt;
      baudCtrl_r <= baudCtrl_nxt;
      divLow_r <= divLow_nxt;
      divHigh_r <= divHigh_nxt;
      intCtrl_r <= intCtrl_nxt;
      txHold_r <= txHold_nxt;
      txHoldFull_r <= txHoldFull_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit shifter

  ssp_pkg::ssp_tx_state_t txState_r, txState_nxt;
  logic [8:0] tsr_r, tsr_nxt;
  logic [3:0] txCnt_r, txCnt_nxt;
  logic txFirst_r, txFirst_nxt, txReady, dataOut_r, dataOut_nxt, dataOeN_r, dataOeN_nxt;

  always_comb begin
    txReady = portOn & txDir & transmit_enable;
    txLoad = 1'b0;
    txState_nxt = txState_r;
    tsr_nxt = tsr_r;
    txCnt_nxt = txCnt_r;
    txFirst_nxt = txFirst_r;
    case (txState_r)
      ssp_pkg::TX_IDLE: begin
        if (txReady & txHoldFull_r) begin
          txLoad = 1'b1;
          tsr_nxt = {txCtrl_r[ssp_pkg::TX_NINTH_BIT], txHold_r};
          txCnt_nxt = txNine ? ssp_pkg::CHAR_BITS_NINE : ssp_pkg::CHAR_BITS_EIGHT;
          txFirst_nxt = 1'b1;
          txState_nxt = ssp_pkg::TX_SHIFT;
        end
      end
      ssp_pkg::TX_SHIFT: begin
        if (~txReady) begin
          txState_nxt = ssp_pkg::TX_IDLE;
        end else if (leadingEdge) begin
          // Bit 0 is already on the pin before the first clock
          txFirst_nxt = 1'b0;
          if (~txFirst_r) begin
            tsr_nxt = {1'b0, tsr_r[8:1]};
          end
        end else if (trailingEdge) begin
          txCnt_nxt = txCnt_r - 4'h1;
          if (txCnt_r == 4'h1) begin
            txState_nxt = ssp_pkg::TX_IDLE;
          end
        end
      end
      default: txState_nxt = ssp_pkg::TX_IDLE;
    endcase
    dataOut_nxt = tsr_nxt[0] ^ baudCtrl_r[ssp_pkg::DATA_POL_BIT];
    dataOeN_nxt = ~txReady;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      txState_r <= ssp_pkg::TX_IDLE;
      tsr_r <= 9'h000;
      txCnt_r <= 4'h0;
      txFirst_r <= 1'b0;
      dataOut_r <= 1'b0;
      dataOeN_r <= 1'b1;
    end else begin
      txState_r <= txState_nxt;
      tsr_r <= tsr_nxt;
      txCnt_r <= txCnt_nxt;
      txFirst_r <= txFirst_nxt;
      dataOut_r <= dataOut_nxt;
      dataOeN_r <= dataOeN_nxt;
    end
  end

  assign txBusy_r = (txState_r == ssp_pkg::TX_SHIFT);

  ////////////////////////////////////////////////////////////////////////////
  // Receive shifter and queue

  logic [8:0] rsr_r, rsr_nxt;
  logic [3:0] rxCnt_r, rxCnt_nxt, rxWidth;
  logic rxDone, dataBit;

  always_comb begin
    rxWidth = rxNine ? ssp_pkg::CHAR_BITS_NINE : ssp_pkg::CHAR_BITS_EIGHT;
    dataBit = dataSync ^ baudCtrl_r[ssp_pkg::DATA_POL_BIT];
    rsr_nxt = rsr_r;
    rxCnt_nxt = rxCnt_r;
    rxDone = 1'b0;
    // Sleep does not gate the receiver
    if (~rxOn) begin
      rxCnt_nxt = 4'h0;
    end else if (trailingEdge) begin
      rsr_nxt = {dataBit, rsr_r[8:1]};
      rxCnt_nxt = rxCnt_r + 4'h1;
      if (rxCnt_nxt == rxWidth) begin
        rxDone = 1'b1;
        rxCnt_nxt = 4'h0;
      end
    end
    rxChar.ninth = rxNine ? rsr_nxt[8] : 1'b0;
    rxChar.low = rxNine ? rsr_nxt[7:0] : rsr_nxt[8:1];
    qPush = rxDone & ~qFull;
    qPop = rdDone & isReg(paddr, ssp_pkg::RX_DATA_OFS);
    rxActive = rxCnt_r != 4'h0;
    // Clear wins: a completion cannot coincide with the clear
    overrun_nxt = (overrun_r | (rxDone & qFull)) & contRx & portEnable;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rsr_r <= 9'h000;
      rxCnt_r <= 4'h0;
      overrun_r <= 1'b0;
    end else begin
      rsr_r <= rsr_nxt;
      rxCnt_r <= rxCnt_nxt;
      overrun_r <= overrun_nxt;
    end
  end

  ssp_rx_queue #(.WIDTH(9), .DEPTH(ssp_pkg::RX_QUEUE_DEPTH)) u_queue (
    .mclk(mclk),
    .rst(rst),
    .flush(~portEnable),
    .push(qPush),
    .pushData(rxChar),
    .pop(qPop),
    .headData(qHead),
    .empty(qEmpty),
    .full(qFull)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt and wake outputs

  logic rxIrq_r, rxIrq_nxt, txIrq_r, txIrq_nxt, wake_r, wake_nxt;

  always_comb begin
    rxIrq_nxt = ~qEmpty & intCtrl_r[ssp_pkg::RX_INT_EN_BIT];
    txIrq_nxt = ~txHoldFull_r & intCtrl_r[ssp_pkg::TX_INT_EN_BIT];
    wake_nxt = coreSleep & rxIrq_nxt;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rxIrq_r <= 1'b0;
      txIrq_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      rxIrq_r <= rxIrq_nxt;
      txIrq_r <= txIrq_nxt;
      wake_r <= wake_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign serialClockPinOut = 1'b0;
  assign serialClockPinOeN = 1'b1;
  assign serialDataPinOut = dataOut_r;
  assign serialDataPinOeN = dataOeN_r;
  assign receiveIrq = rxIrq_r;
  assign transmitIrq = txIrq_r;
  assign wakeReq = wake_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  rx_push_flag_a: assert property (rxDone && !qFull |=> !qEmpty ##1 (rxIrq_r ||
      !$past(intCtrl_r[ssp_pkg::RX_INT_EN_BIT]))) else $error("receive flag missing");
  overrun_set_a: assert property (rxDone && qFull |=> overrun_r)
    else $error("overrun not set");
  overrun_block_a: assert property (overrun_r |-> !qPush && !rxActive)
    else $error("character taken during overrun");
  overrun_clear_a: assert property (!contRx |=> !overrun_r)
    else $error("overrun survives receive disable");
  tx_gate_a: assert property (!transmit_enable |=> !txBusy_r)
    else $error("transmission without enable");
  tx_start_a: assert property (wrTxHold && txReady && !txBusy_r && !txHoldFull_r ##1
      txReady |=> txBusy_r) else $error("write did not start shifting");
  tx_nine_a: assert property (txLoad |=> txCnt_r == (txNine ? 4'h9 : 4'h8))
    else $error("wrong transmit length");
  tx_dir_a: assert property (!serialDataPinOeN |-> !$past(contRx) && !$past(singleRx))
    else $error("data driven in receive direction");
  rx_width_a: assert property (rxCnt_r < rxWidth)
    else $error("receive count beyond character");
  wake_a: assert property (coreSleep && rxDone && !qFull &&
      intCtrl_r[ssp_pkg::RX_INT_EN_BIT] |=> ##1 wakeReq) else $error("no wake");
endmodule
`default_nettype wire

// ---- verif/ssp_link_master.sv ----
// Model of the external synchronous master on the clock and data pins.
// Assumes clock polarity 0: the rising edge leads and the falling edge trails.
`default_nettype none
module ssp_link_master #(
  parameter int HALF_NS = 24
) (
  output logic linkClk,
  output logic linkData,
  input wire logic linkDataIn
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    linkClk = 1'b0;
    linkData = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One frame: drives txBits and samples the pin at once, LSB first
  task automatic frame(input logic [8:0] txBits, input int n, output logic [8:0] rxBits);
    rxBits = 9'h000;
    // Off-grid start keeps the link unrelated in phase to mclk
    #1.3;
    for (int i = 0; i < n; i++) begin
      linkClk = 1'b1;
      linkData = txBits[i];
      #(HALF_NS);
      linkClk = 1'b0;
      rxBits[i] = linkDataIn;
      #(HALF_NS);
    end
    // Released line must not keep the last bit
    linkData = ~linkData;
    #(4 * HALF_NS);
  endtask
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench of the slave serial port over APB and the link pins.
// Assumes the link master model drives the clock pin; the data pin is shared.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LIMIT = 20000;
  localparam logic [7:0] RXC = ssp_pkg::RX_STATUS_CTRL_OFS;
  localparam logic [7:0] TXC = ssp_pkg::TX_STATUS_CTRL_OFS;
  localparam logic [7:0] INTC = ssp_pkg::INT_CTRL_OFS;
  localparam logic [7:0] RXD = ssp_pkg::RX_DATA_OFS;
  logic mclk = 1'b0;
  logic rst, psel, penable, pwrite, coreSleep, pready, pslverr, err;
  logic clkOut, clkOeN, dataOut, dataOeN, receiveIrq, transmitIrq, wakeReq;
  logic linkClk, linkData, clkWire, dataWire;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0] got;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;

  assign clkWire = clkOeN ? linkClk : clkOut;
  assign dataWire = dataOeN ? linkData : dataOut;

  ssp_slave_port dut(.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serialClockPinIn(clkWire),
    .serialClockPinOut(clkOut), .serialClockPinOeN(clkOeN),
    .serialDataPinIn(dataWire), .serialDataPinOut(dataOut),
    .serialDataPinOeN(dataOeN), .coreSleep(coreSleep), .receiveIrq(receiveIrq),
    .transmitIrq(transmitIrq), .wakeReq(wakeReq));
  ssp_link_master master(.linkClk(linkClk), .linkData(linkData), .linkDataIn(dataWire));

  always #2 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    if (errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Waits as long as the slave needs; only the bench timeout ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rd & m, exp);
  endtask

  // Registered pins settle a couple of cycles after the write edge
  // Pin is read after the wait, not when the task is called
  task automatic pinChk(input string what, input logic exp);
    repeat (3) @(negedge mclk);
    check(what, {31'h0, dataOeN}, {31'h0, exp});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic rx_scn;
    apb(1'b1, TXC, 32'h10);
    apb(1'b1, INTC, 32'h01);
    apb(1'b1, RXC, 32'h90);
    pinChk("rx data oe", 1'b1);
    check("clk oe", {31'h0, clkOeN}, 32'h1);
    master.frame(9'h03C, 8, got);
    check("rx irq", {31'h0, receiveIrq}, 32'h1);
    rdChk("rx flag", INTC, 32'h10, 32'h10);
    rdChk("rx byte", RXD, 32'hFFFFFFFF, 32'h3C);
    rdChk("rx flag low", INTC, 32'h10, 32'h0);
    // Inverted data polarity flips every received bit
    apb(1'b1, ssp_pkg::BAUD_POL_CTRL_OFS, 32'h20);
    master.frame(9'h0F0, 8, got);
    rdChk("inverted", RXD, 32'hFF, 32'h0F);
    apb(1'b1, ssp_pkg::BAUD_POL_CTRL_OFS, 32'h00);
  endtask

  task automatic nine_scn;
    apb(1'b1, RXC, 32'hF0);
    coreSleep <= 1'b1;
    master.frame(9'h1A5, 9, got);
    check("wake", {31'h0, wakeReq}, 32'h1);
    @(posedge mclk);
    coreSleep <= 1'b0;
    rdChk("ninth", RXC, 32'h1, 32'h1);
    rdChk("nine low", RXD, 32'hFFFFFFFF, 32'hA5);
  endtask

  task automatic ovr_scn;
    apb(1'b1, RXC, 32'h90);
    for (int i = 1; i < 5; i++) begin
      master.frame(9'(i * 9'h011), 8, got);
    end
    rdChk("overrun", RXC, 32'h2, 32'h2);
    rdChk("first", RXD, 32'hFF, 32'h11);
    rdChk("second", RXD, 32'hFF, 32'h22);
    rdChk("no third", INTC, 32'h10, 32'h0);
    apb(1'b1, RXC, 32'h80);
    rdChk("overrun clr", RXC, 32'h2, 32'h0);
  endtask

  task automatic tx_scn;
    apb(1'b1, RXC, 32'h90);
    apb(1'b1, TXC, 32'h51);
    pinChk("oe no transmit_enable", 1'b1);
    apb(1'b1, TXC, 32'h71);
    pinChk("oe rx on", 1'b1);
    apb(1'b1, RXC, 32'h80);
    pinChk("oe tx", 1'b0);
    apb(1'b1, INTC, 32'h02);
    apb(1'b1, ssp_pkg::TX_HOLDING_OFS, 32'hC3);
    master.frame(9'h000, 9, got);
    check("tx char", {23'h0, got}, 32'h1C3);
    check("tx irq", {31'h0, transmitIrq}, 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped", {31'h0, err}, 32'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      conclude();
    end
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    coreSleep = 1'b0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rx_scn();
    nine_scn();
    ovr_scn();
    tx_scn();
    conclude();
  end
endmodule
`default_nettype wire
